//--- cfas_pkg.sv
package cfas_pkg;

	localparam int NUM_CELLS = 14;
	localparam int NUM_AUX   = 6;

	// register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_CELL_UV = 8'h0F;
	localparam logic [7:0] IDX_AUX_OV  = 8'h10;
	localparam logic [7:0] IDX_AUX_UV  = 8'h11;
	localparam logic [7:0] IDX_IRQ_STS = 8'h20;
	localparam logic [7:0] IDX_IRQ_MSK = 8'h21;

	localparam logic [15:0] RST_ALERT = 16'h0000;
	localparam logic [2:0]  RST_MASK  = 3'h0;

	// interrupt status and mask layout
	localparam int IRQ_CELL_UV_BIT = 0;
	localparam int IRQ_AUX_OV_BIT  = 1;
	localparam int IRQ_AUX_UV_BIT  = 2;

	// one comparator acquisition result
	typedef struct packed {
		logic [NUM_CELLS-1:0] cell_below_uv;
		logic [NUM_AUX-1:0]   aux_above_ov;
		logic [NUM_AUX-1:0]   aux_below_uv;
	} cfas_acq_t;

	typedef struct packed {
		logic [NUM_CELLS-1:0] cell_uv_alert_enable;
		logic [NUM_AUX-1:0]   aux_ov_alert_enable;
		logic [NUM_AUX-1:0]   aux_uv_alert_enable;
	} cfas_en_t;

endpackage : cfas_pkg

//--- cfas_top.sv
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - per-cell undervoltage alert bits, enabled only
// R2 - per-input aux overvoltage alert bits 5:0
// R3 - aux overvoltage bit needs its enable set
// R4 - per-input aux undervoltage alert bits 5:0
// R5 - aux undervoltage bit needs its enable set
// R6 - cell UV, aux OV clear when fault gone
// R7 - aux UV clears when fault gone
// R8 - writes ignored, upper bits zero, reset clear
module cfas_top
	import cfas_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	// comparator acquisition
	input  wire logic        acq_valid_i,
	input  wire cfas_acq_t   acq_i,
	input  wire cfas_en_t    en_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	// interrupt
	output logic             irq_o
);

	logic [NUM_CELLS-1:0] cell_uv_cmp_alert_q;
	logic [NUM_AUX-1:0]   aux_ov_cmp_alert_q;
	logic [NUM_AUX-1:0]   aux_uv_cmp_alert_q;
	logic [NUM_CELLS-1:0] cell_uv_d;
	logic [NUM_AUX-1:0]   aux_ov_d;
	logic [NUM_AUX-1:0]   aux_uv_d;
	logic [2:0]           irq_sts_q;
	logic [2:0]           irq_msk_q;
	logic [2:0]           irq_set;
	logic [2:0]           irq_sts_d;

	// each acquisition replaces the bits: set while fault and enabled, cleared once gone
	assign cell_uv_d = acq_i.cell_below_uv & en_i.cell_uv_alert_enable; // R1 R6
	assign aux_ov_d  = acq_i.aux_above_ov & en_i.aux_ov_alert_enable;   // R2 R3 R6
	assign aux_uv_d  = acq_i.aux_below_uv & en_i.aux_uv_alert_enable;   // R4 R5 R7

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cell_uv_cmp_alert_q <= RST_ALERT[NUM_CELLS-1:0]; // R8
			aux_ov_cmp_alert_q  <= RST_ALERT[NUM_AUX-1:0];
			aux_uv_cmp_alert_q  <= RST_ALERT[NUM_AUX-1:0];
		end else if (acq_valid_i) begin
			cell_uv_cmp_alert_q <= cell_uv_d;
			aux_ov_cmp_alert_q  <= aux_ov_d;
			aux_uv_cmp_alert_q  <= aux_uv_d;
		end
	end

	// bus decode
	wire        bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire        adr_ok   = (wb_adr_i[1:0] == 2'h0);
	wire [7:0]  idx      = wb_adr_i[9:2];
	wire        sel_cuv  = adr_ok & (idx == IDX_CELL_UV);
	wire        sel_aov  = adr_ok & (idx == IDX_AUX_OV);
	wire        sel_auv  = adr_ok & (idx == IDX_AUX_UV);
	wire        sel_sts  = adr_ok & (idx == IDX_IRQ_STS);
	wire        sel_msk  = adr_ok & (idx == IDX_IRQ_MSK);
	wire        hit      = sel_cuv | sel_aov | sel_auv | sel_sts | sel_msk;
	wire        wr_lo    = bus_req & wb_we_i & wb_sel_i[0];
	wire        sts_wr   = wr_lo & sel_sts;
	wire        msk_wr   = wr_lo & sel_msk;
	// alert registers take no write: only status and mask decode a write
	wire [31:0] rd_data  = sel_cuv ? {18'h0, cell_uv_cmp_alert_q} :   // R8
	                       sel_aov ? {26'h0, aux_ov_cmp_alert_q} :
	                       sel_auv ? {26'h0, aux_uv_cmp_alert_q} :
	                       sel_sts ? {29'h0, irq_sts_q} :
	                       sel_msk ? {29'h0, irq_msk_q} : 32'h0;

	// an alert rising at acquisition is an event; set beats a write-one clear
	assign irq_set[IRQ_CELL_UV_BIT] = acq_valid_i & |(cell_uv_d & ~cell_uv_cmp_alert_q);
	assign irq_set[IRQ_AUX_OV_BIT]  = acq_valid_i & |(aux_ov_d & ~aux_ov_cmp_alert_q);
	assign irq_set[IRQ_AUX_UV_BIT]  = acq_valid_i & |(aux_uv_d & ~aux_uv_cmp_alert_q);
	assign irq_sts_d = (irq_sts_q & ~(sts_wr ? wb_dat_i[2:0] : 3'h0)) | irq_set;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_sts_q <= 3'h0;
			irq_msk_q <= RST_MASK;
			irq_o     <= 1'b0;
			wb_ack_o  <= 1'b0;
			wb_err_o  <= 1'b0;
			wb_dat_o  <= 32'h0;
		end else begin
			irq_sts_q <= irq_sts_d;
			if (msk_wr)
				irq_msk_q <= wb_dat_i[2:0];
			irq_o     <= |(irq_sts_q & irq_msk_q);
			wb_ack_o  <= bus_req & hit;
			wb_err_o  <= bus_req & ~hit;
			wb_dat_o  <= (bus_req & hit & ~wb_we_i) ? rd_data : 32'h0;
		end
	end

	property p_cell_uv_follow;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		acq_valid_i |=> cell_uv_cmp_alert_q == $past(acq_i.cell_below_uv & en_i.cell_uv_alert_enable);
	endproperty
	a_cell_uv_follow: assert property (p_cell_uv_follow) else $error("cell uv alert wrong"); // R1

	property p_aux_ov_set;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		acq_valid_i && (acq_i.aux_above_ov[0] && en_i.aux_ov_alert_enable[0])
		|=> aux_ov_cmp_alert_q[0];
	endproperty
	a_aux_ov_set: assert property (p_aux_ov_set) else $error("aux ov alert not set"); // R2

	property p_aux_ov_en;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		acq_valid_i |=> (aux_ov_cmp_alert_q & ~$past(en_i.aux_ov_alert_enable)) == '0;
	endproperty
	a_aux_ov_en: assert property (p_aux_ov_en) else $error("aux ov alert without enable"); // R3

	property p_aux_uv_set;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		acq_valid_i |=> aux_uv_cmp_alert_q == $past(acq_i.aux_below_uv & en_i.aux_uv_alert_enable);
	endproperty
	a_aux_uv_set: assert property (p_aux_uv_set) else $error("aux uv alert wrong"); // R4

	property p_aux_uv_en;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		acq_valid_i && !en_i.aux_uv_alert_enable[5] |=> !aux_uv_cmp_alert_q[5];
	endproperty
	a_aux_uv_en: assert property (p_aux_uv_en) else $error("aux uv alert without enable"); // R5

	property p_hold;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!acq_valid_i |=> $stable(cell_uv_cmp_alert_q) && $stable(aux_ov_cmp_alert_q);
	endproperty
	a_hold: assert property (p_hold) else $error("alert changed without acquisition"); // R6

	property p_aux_uv_clear;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		acq_valid_i && !acq_i.aux_below_uv[0] |=> !aux_uv_cmp_alert_q[0];
	endproperty
	a_aux_uv_clear: assert property (p_aux_uv_clear) else $error("aux uv alert not cleared"); // R7

	property p_read_upper_zero;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		wb_ack_o |-> wb_dat_o[31:16] == 16'h0;
	endproperty
	a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper bits not zero"); // R8

	property p_write_ignored;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_req && wb_we_i && sel_cuv && !acq_valid_i |=> $stable(cell_uv_cmp_alert_q);
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("alert took a write"); // R8

	property p_ack_one;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");

	// per-bit set check, so a stuck bit names its own cell
	for (genvar n = 0; n < NUM_CELLS; n++) begin : g_cell_chk
		property p_cell_bit_set;
			@(posedge clk_sys_i) disable iff (!rst_n_i)
			acq_valid_i && acq_i.cell_below_uv[n] && en_i.cell_uv_alert_enable[n]
			|=> cell_uv_cmp_alert_q[n];
		endproperty
		a_cell_bit_set: assert property (p_cell_bit_set) else $error("cell bit not set"); // R1
	end

	property p_cell_uv_en;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		acq_valid_i |=> (cell_uv_cmp_alert_q & ~$past(en_i.cell_uv_alert_enable)) == '0;
	endproperty
	a_cell_uv_en: assert property (p_cell_uv_en) else $error("cell uv alert without enable"); // R1

	property p_cell_uv_clear;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		acq_valid_i |=> (cell_uv_cmp_alert_q & ~$past(acq_i.cell_below_uv)) == '0;
	endproperty
	a_cell_uv_clear: assert property (p_cell_uv_clear) else $error("cell uv not cleared"); // R6

	property p_aux_ov_clear;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		acq_valid_i |=> (aux_ov_cmp_alert_q & ~$past(acq_i.aux_above_ov)) == '0;
	endproperty
	a_aux_ov_clear: assert property (p_aux_ov_clear) else $error("aux ov not cleared"); // R6

	property p_aux_ov_follow;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		acq_valid_i |=> aux_ov_cmp_alert_q == $past(acq_i.aux_above_ov & en_i.aux_ov_alert_enable);
	endproperty
	a_aux_ov_follow: assert property (p_aux_ov_follow) else $error("aux ov alert wrong"); // R2

	property p_aux_uv_hold;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!acq_valid_i |=> $stable(aux_uv_cmp_alert_q);
	endproperty
	a_aux_uv_hold: assert property (p_aux_uv_hold) else $error("aux uv changed idle"); // R7

	property p_aux_uv_clear_all;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		acq_valid_i |=> (aux_uv_cmp_alert_q & ~$past(acq_i.aux_below_uv)) == '0;
	endproperty
	a_aux_uv_clear_all: assert property (p_aux_uv_clear_all) else $error("aux uv kept"); // R7

	property p_aux_uv_en_all;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		acq_valid_i |=> (aux_uv_cmp_alert_q & ~$past(en_i.aux_uv_alert_enable)) == '0;
	endproperty
	a_aux_uv_en_all: assert property (p_aux_uv_en_all) else $error("aux uv not enabled"); // R5

	property p_write_ignored_aov;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_req && wb_we_i && sel_aov && !acq_valid_i |=> $stable(aux_ov_cmp_alert_q);
	endproperty
	a_write_ignored_aov: assert property (p_write_ignored_aov) else $error("aux ov took write"); // R8

	property p_write_ignored_auv;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_req && wb_we_i && sel_auv && !acq_valid_i |=> $stable(aux_uv_cmp_alert_q);
	endproperty
	a_write_ignored_auv: assert property (p_write_ignored_auv) else $error("aux uv took write"); // R8

	property p_read_cuv_zero;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_req && sel_cuv && !wb_we_i |=> wb_dat_o[31:NUM_CELLS] == '0;
	endproperty
	a_read_cuv_zero: assert property (p_read_cuv_zero) else $error("cell upper bits set"); // R8

	property p_read_aux_zero;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_req && (sel_aov || sel_auv) && !wb_we_i |=> wb_dat_o[31:NUM_AUX] == '0;
	endproperty
	a_read_aux_zero: assert property (p_read_aux_zero) else $error("aux upper bits set"); // R8

	property p_read_cuv_data;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_req && sel_cuv && !wb_we_i
		|=> wb_dat_o[NUM_CELLS-1:0] == $past(cell_uv_cmp_alert_q);
	endproperty
	a_read_cuv_data: assert property (p_read_cuv_data) else $error("cell read wrong"); // R1

	property p_read_aov_data;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_req && sel_aov && !wb_we_i |=> wb_dat_o[NUM_AUX-1:0] == $past(aux_ov_cmp_alert_q);
	endproperty
	a_read_aov_data: assert property (p_read_aov_data) else $error("aux ov read wrong"); // R2

	property p_read_auv_data;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_req && sel_auv && !wb_we_i |=> wb_dat_o[NUM_AUX-1:0] == $past(aux_uv_cmp_alert_q);
	endproperty
	a_read_auv_data: assert property (p_read_auv_data) else $error("aux uv read wrong"); // R4

	property p_ack_answer;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_req && hit |=> wb_ack_o && !wb_err_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("mapped request not acked");

	property p_err_answer;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_req && !hit |=> wb_err_o && !wb_ack_o;
	endproperty
	a_err_answer: assert property (p_err_answer) else $error("unmapped request not refused");

	property p_err_one;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		wb_err_o |=> !wb_err_o;
	endproperty
	a_err_one: assert property (p_err_one) else $error("err longer than one cycle");

	property p_dat_idle;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!wb_ack_o |-> wb_dat_o == '0;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

	property p_irq_level;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		1'b1 |=> irq_o == $past(|(irq_sts_q & irq_msk_q));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

	// set must win over a write-one clear in the same cycle
	property p_sts_set;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		|irq_set |=> (irq_sts_q & $past(irq_set)) == $past(irq_set);
	endproperty
	a_sts_set: assert property (p_sts_set) else $error("status event lost");

	property p_sts_hold;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!sts_wr && irq_set == 3'h0 |=> $stable(irq_sts_q);
	endproperty
	a_sts_hold: assert property (p_sts_hold) else $error("status changed idle");

	property p_msk_write;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		msk_wr |=> irq_msk_q == $past(wb_dat_i[2:0]);
	endproperty
	a_msk_write: assert property (p_msk_write) else $error("mask write lost");

	property p_msk_hold;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!msk_wr |=> $stable(irq_msk_q);
	endproperty
	a_msk_hold: assert property (p_msk_hold) else $error("mask changed idle");

	// a write strobe without sel bit 0 must leave the mask alone
	property p_msk_sel;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_req && wb_we_i && sel_msk && !wb_sel_i[0] |=> $stable(irq_msk_q);
	endproperty
	a_msk_sel: assert property (p_msk_sel) else $error("mask took unselected write");

	property p_sts_clear;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		sts_wr && irq_set == 3'h0 |=> (irq_sts_q & $past(wb_dat_i[2:0])) == 3'h0;
	endproperty
	a_sts_clear: assert property (p_sts_clear) else $error("status not cleared");

endmodule : cfas_top
`default_nettype wire

//--- cfas_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module cfas_top_test import cfas_pkg::*;;
	logic        clk_sys_i   = 1'b0;
	logic        rst_n_i     = 1'b0;
	logic        acq_valid_i = 1'b0;
	cfas_acq_t   acq_i       = '0;
	cfas_en_t    en_i        = '0;
	logic        wb_cyc_i    = 1'b0;
	logic        wb_stb_i    = 1'b0;
	logic        wb_we_i     = 1'b0;
	logic [9:0]  wb_adr_i    = 10'h000;
	logic [31:0] wb_dat_i    = 32'h0;
	logic [3:0]  wb_sel_i    = 4'hF;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        wb_err_o;
	logic        irq_o;
	logic [31:0] rd;
	logic        er;
	int          miscompares = 0;
	int          checked     = 0;
	int          cycles      = 0;
	cfas_top uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .acq_valid_i(acq_valid_i),
		.acq_i(acq_i), .en_i(en_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irq_o(irq_o));
	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// request held until ack or err is sampled, then one idle cycle
	task automatic bus(input logic we, input logic [9:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_sys_i); while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
		rd = wb_dat_o;
		er = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask : bus
	// inputs flipped after the pulse so sampling outside valid would show
	task automatic acq(input cfas_acq_t a, input cfas_en_t e);
		acq_valid_i <= 1'b1;
		acq_i       <= a;
		en_i        <= e;
		@(posedge clk_sys_i);
		acq_valid_i <= 1'b0;
		acq_i       <= ~a;
		en_i        <= ~e;
		@(posedge clk_sys_i);
	endtask : acq
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		repeat (10) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		for (int i = 0; i < 3; i++) begin
			bus(1'b0, 10'h03C + 10'(4 * i), 32'h0);
			chk("alert reset", rd, 32'h0);
		end
		$display("test reset done");
		acq('{14'h3FFF, 6'h3F, 6'h3F}, '{14'h2AAA, 6'h15, 6'h2A});
		bus(1'b0, 10'h03C, 32'h0);
		chk("cell uv", rd, 32'h2AAA);
		bus(1'b0, 10'h040, 32'h0);
		chk("aux ov", rd, 32'h15);
		bus(1'b0, 10'h044, 32'h0);
		chk("aux uv", rd, 32'h2A);
		bus(1'b1, 10'h03C, 32'hFFFFFFFF);
		chk("ro write err", er, 32'h0);
		bus(1'b0, 10'h03C, 32'h0);
		chk("cell uv kept", rd, 32'h2AAA);
		$display("test alerts done");
		chk("irq masked", irq_o, 32'h0);
		bus(1'b0, 10'h080, 32'h0);
		chk("status", rd, 32'h7);
		bus(1'b1, 10'h084, 32'h7);
		@(posedge clk_sys_i);
		chk("irq set", irq_o, 32'h1);
		bus(1'b1, 10'h080, 32'h7);
		@(posedge clk_sys_i);
		chk("irq clear", irq_o, 32'h0);
		$display("test irq done");
		acq('{14'h0AAA, 6'h10, 6'h00}, '{14'h2AAA, 6'h15, 6'h2A});
		bus(1'b0, 10'h03C, 32'h0);
		chk("cell uv cleared", rd, 32'h0AAA);
		bus(1'b0, 10'h040, 32'h0);
		chk("aux ov cleared", rd, 32'h10);
		bus(1'b0, 10'h044, 32'h0);
		chk("aux uv cleared", rd, 32'h0);
		chk("irq no rise", irq_o, 32'h0);
		bus(1'b0, 10'h048, 32'h0);
		chk("unmapped err", er, 32'h1);
		$display("test clear done");
		complete_run();
	end
endmodule : cfas_top_test
`default_nettype wire
